// File: hw/smr_pkg.sv
`default_nettype none
package smr_pkg;
	// ==========================================================
	// register map
	localparam logic [3:0] SMR_ADDR_CSR     = 4'h0;
	localparam logic [3:0] SMR_ADDR_IRQ_ST  = 4'h1;
	localparam logic [3:0] SMR_ADDR_IRQ_EN  = 4'h2;
	localparam logic [3:0] SMR_ADDR_IRQ_CLR = 4'h3;
	localparam int SMR_BIT_SEL  = 7;
	localparam int SMR_BIT_IE   = 6;
	localparam int SMR_BIT_FLAG = 5;
	localparam int SMR_BIT_LVRF = 4;
	localparam int SMR_BIT_WDRF = 0;
	localparam logic [7:0] SMR_CSR_RST = 8'h00;
	localparam int SMR_EV_CHANGE = 0;
	localparam int SMR_EV_ENABLE = 1;
	// ==========================================================
	// reset delay options, in cpu cycles
	localparam logic [12:0] SMR_DLY_SHORT = 13'h0100;
	localparam logic [12:0] SMR_DLY_LONG  = 13'h1000;

	typedef enum logic [1:0] {
		SMR_RST_EXT = 2'h0,
		SMR_RST_WDG = 2'h1,
		SMR_RST_LOWVOLT = 2'h2
	} smr_src_e;

	typedef struct packed {
		logic       sel;
		logic       ie;
		logic       lvrf;
		logic       wdrf;
		logic [1:0] sync;
		logic       flag;
		logic       pend;
		logic [1:0] irq_st;
		logic [1:0] irq_en;
		logic [12:0] dly;
		logic       first;
		logic [7:0] rdata;
		logic       irq;
		logic       cpu_irq;
		logic       wake;
	} smr_state_s;
endpackage : smr_pkg
`default_nettype wire

// File: hw/smr_top.sv
// Design decisions made here: the placing of the registers and strobed register access.
`default_nettype none
module smr_top
	import smr_pkg::*;
#(
	parameter logic [12:0] RESET_DELAY_LONG  = smr_pkg::SMR_DLY_LONG,
	parameter logic [12:0] RESET_DELAY_SHORT = smr_pkg::SMR_DLY_SHORT
)(
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [1:0] rst_src_i,
	input  wire logic       lowvolt_det_en_i,
	input  wire logic       long_delay_i,
	input  wire logic       cmp_supply_i,
	input  wire logic       cmp_sense_i,
	input  wire logic       halt_i,
	input  wire logic       cpu_mask_i,
	input  wire logic       irq_ack_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            cpu_irq_o,
	output logic            wake_o,
	output logic            irq_o
);
	import smr_pkg::*;

	smr_state_s s_q;
	smr_state_s s_d;
	logic       raw;
	logic       csr_wr;
	logic       frozen;
	logic [7:0] csr_rd;
	logic [1:0] ev;

	// ==========================================================
	// address decode, used by the write paths and the read checks; the read mux decodes addr_i itself
	function automatic logic reg_hit(
		input logic [3:0] addr,
		input logic [3:0] target
	);
		return addr == target;
	endfunction

	// ==========================================================
	// comparator select and sync
	assign raw    = s_q.sel ? cmp_sense_i : cmp_supply_i;
	assign frozen = halt_i;
	assign csr_wr = wr_i && reg_hit(addr_i, SMR_ADDR_CSR) && !frozen;

	always_comb
	begin
		csr_rd = 8'h00; // reserved bits read zero
		csr_rd[SMR_BIT_SEL]  = s_q.sel;
		csr_rd[SMR_BIT_IE]   = s_q.ie;
		csr_rd[SMR_BIT_FLAG] = s_q.flag;
		csr_rd[SMR_BIT_LVRF] = s_q.lvrf; // meaningless without detector
		csr_rd[SMR_BIT_WDRF] = s_q.wdrf;
	end

	// ==========================================================
	// next state
	always_comb
	begin
		s_d = s_q;
		ev  = 2'h0;
		if (!frozen)
		begin
			s_d.sync = {s_q.sync[0], raw};
			if (s_q.dly != 13'h0000)
				s_d.dly = s_q.dly - 13'h0001;
			if (lowvolt_det_en_i)
			begin
				if (s_q.sync[1] != s_q.flag)
				begin
					s_d.flag = s_q.sync[1];
					// flag changes in either direction inside reset delay are silent
					if (s_q.ie && !(s_q.first && s_q.dly != 13'h0000))
						ev[SMR_EV_CHANGE] = 1'b1;
				end
			end
			if (csr_wr)
			begin
				s_d.sel = wdata_i[SMR_BIT_SEL];
				s_d.ie  = wdata_i[SMR_BIT_IE];
				// enabling while the flag is set gives its own interrupt
				if (wdata_i[SMR_BIT_IE] && !s_q.ie && s_q.flag && lowvolt_det_en_i)
					ev[SMR_EV_ENABLE] = 1'b1;
				if (!wdata_i[SMR_BIT_LVRF])
					s_d.lvrf = 1'b0;
				if (!wdata_i[SMR_BIT_WDRF])
					s_d.wdrf = 1'b0;
			end
			if (s_q.dly == 13'h0000)
				s_d.first = 1'b0;
		end
		// set wins over the acknowledge
		if (irq_ack_i)
			s_d.pend = 1'b0;
		if (ev != 2'h0)
			s_d.pend = 1'b1;
		if (wr_i && reg_hit(addr_i, SMR_ADDR_IRQ_EN))
			s_d.irq_en = wdata_i[1:0];
		if (wr_i && reg_hit(addr_i, SMR_ADDR_IRQ_CLR))
			s_d.irq_st = s_q.irq_st & ~wdata_i[1:0];
		s_d.irq_st = s_d.irq_st | ev;
		s_d.irq    = |(s_d.irq_st & s_d.irq_en);
		// registered outputs: mask and halt take effect one cycle late
		s_d.cpu_irq = s_d.pend && s_d.ie && !cpu_mask_i;
		s_d.wake    = s_d.pend && s_d.ie && !halt_i;
		s_d.rdata  = 8'h00;
		if (rd_i)
		begin
			case (addr_i)
				SMR_ADDR_CSR:    s_d.rdata = csr_rd;
				SMR_ADDR_IRQ_ST: s_d.rdata = {6'h00, s_q.irq_st};
				SMR_ADDR_IRQ_EN: s_d.rdata = {6'h00, s_q.irq_en};
				default:         s_d.rdata = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			s_q        <= '0;
			s_q.dly    <= long_delay_i ? RESET_DELAY_LONG : RESET_DELAY_SHORT;
			s_q.first  <= 1'b1;
			// source flags survive reset per source
			s_q.lvrf   <= (rst_src_i == SMR_RST_LOWVOLT) ? 1'b1 : s_q.lvrf;
			s_q.wdrf   <= (rst_src_i == SMR_RST_WDG) ? 1'b1 :
				(rst_src_i == SMR_RST_LOWVOLT) ? 1'b0 : s_q.wdrf;
			s_q.flag   <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign rdata_o   = s_q.rdata;
	assign irq_o     = s_q.irq;
	assign cpu_irq_o = s_q.cpu_irq;
	assign wake_o    = s_q.wake;

	// ==========================================================
	// checks
	a_flag_sync: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!halt_i && lowvolt_det_en_i && s_q.sync[1] != s_q.flag) |=> s_q.flag == $past(s_q.sync[1]))
		else $error("flag did not follow synchronised comparator");
	a_halt_frozen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		halt_i |=> $stable(s_q.sel) && $stable(s_q.ie) && $stable(s_q.flag))
		else $error("register changed in halt");
	a_ack_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(irq_ack_i && ev == 2'h0) |=> !s_q.pend)
		else $error("pending not cleared by acknowledge");
	a_event_pend: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(ev != 2'h0) |=> s_q.pend && s_q.irq_st != 2'h0)
		else $error("event lost");
	a_mask_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		cpu_mask_i |=> !cpu_irq_o)
		else $error("interrupt passed global mask");
	a_no_detector: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!lowvolt_det_en_i |=> $stable(s_q.flag))
		else $error("flag moved with detector disabled");
	a_lvrf_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(csr_wr && !wdata_i[SMR_BIT_LVRF]) |=> !s_q.lvrf)
		else $error("lowvolt flag not cleared");
	a_delay_silent: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s_q.first && s_q.dly != 13'h0000) |-> !ev[SMR_EV_CHANGE])
		else $error("interrupt inside reset delay");

	// ==========================================================
	// register port checks
	a_sel_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		csr_wr
		|=> s_q.sel == $past(wdata_i[SMR_BIT_SEL]))
		else $error("select bit not written");

	a_ie_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		csr_wr
		|=> s_q.ie == $past(wdata_i[SMR_BIT_IE]))
		else $error("enable bit not written");

	a_sel_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!csr_wr
		|=> $stable(s_q.sel))
		else $error("select bit moved without a write");

	a_ie_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!csr_wr
		|=> $stable(s_q.ie))
		else $error("enable bit moved without a write");

	a_wdrf_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(csr_wr && !wdata_i[SMR_BIT_WDRF])
		|=> !s_q.wdrf)
		else $error("watchdog flag not cleared");

	a_lvrf_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(csr_wr && wdata_i[SMR_BIT_LVRF])
		|=> $stable(s_q.lvrf))
		else $error("writing one changed lowvolt flag");

	a_wdrf_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(csr_wr && wdata_i[SMR_BIT_WDRF])
		|=> $stable(s_q.wdrf))
		else $error("writing one changed watchdog flag");

	a_lvrf_no_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!s_q.lvrf
		|=> !s_q.lvrf)
		else $error("lowvolt flag set outside reset");

	a_wdrf_no_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!s_q.wdrf
		|=> !s_q.wdrf)
		else $error("watchdog flag set outside reset");

	a_rd_csr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(rd_i && reg_hit(addr_i, SMR_ADDR_CSR))
		|=> rdata_o == $past(csr_rd))
		else $error("control read data wrong");

	a_rd_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(rd_i && reg_hit(addr_i, SMR_ADDR_CSR))
		|=> rdata_o[SMR_BIT_LVRF-1:SMR_BIT_WDRF+1] == '0)
		else $error("reserved bits read nonzero");

	a_en_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(wr_i && reg_hit(addr_i, SMR_ADDR_IRQ_EN))
		|=> s_q.irq_en == $past(wdata_i[1:0]))
		else $error("interrupt enable not written");

	a_clr_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(wr_i && reg_hit(addr_i, SMR_ADDR_IRQ_CLR) && ev == 2'h0)
		|=> (s_q.irq_st & $past(wdata_i[1:0])) == 2'h0)
		else $error("status bit not cleared");

	a_rd_status: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(rd_i && reg_hit(addr_i, SMR_ADDR_IRQ_ST))
		|=> rdata_o[1:0] == $past(s_q.irq_st))
		else $error("status read data wrong");

	// ==========================================================
	// flag, delay and halt checks
	a_sync_shift: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!halt_i
		|=> s_q.sync[1] == $past(s_q.sync[0]))
		else $error("second sync stage did not shift");

	a_sync_take: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!halt_i
		|=> s_q.sync[0] == $past(raw))
		else $error("first sync stage did not sample");

	a_flag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_q.sync[1] == s_q.flag
		|=> $stable(s_q.flag))
		else $error("flag moved without comparator change");

	a_halt_sync: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		halt_i
		|=> $stable(s_q.sync))
		else $error("synchroniser moved in halt");

	a_dly_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!halt_i && s_q.dly != 13'h0000)
		|=> s_q.dly == $past(s_q.dly) - 13'h0001)
		else $error("reset delay did not count");

	a_dly_rest: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_q.dly == 13'h0000
		|=> s_q.dly == 13'h0000)
		else $error("reset delay restarted");

	a_first_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!halt_i && s_q.dly == 13'h0000)
		|=> !s_q.first)
		else $error("power-up window not closed");

	a_first_stay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!s_q.first
		|=> !s_q.first)
		else $error("power-up window reopened");

	a_halt_flags: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		halt_i
		|=> $stable(s_q.lvrf) && $stable(s_q.wdrf))
		else $error("reset flags changed in halt");

	a_halt_delay: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		halt_i
		|=> $stable(s_q.dly))
		else $error("reset delay counted in halt");

	// ==========================================================
	// event and interrupt checks
	a_no_det_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!lowvolt_det_en_i
		|-> ev == 2'h0)
		else $error("event with detector disabled");

	a_change_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		ev[SMR_EV_CHANGE]
		|=> s_q.irq_st[SMR_EV_CHANGE])
		else $error("change event not recorded");

	a_enable_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(csr_wr && wdata_i[SMR_BIT_IE] && !s_q.ie && s_q.flag && lowvolt_det_en_i)
		|=> s_q.irq_st[SMR_EV_ENABLE])
		else $error("enable event not recorded");

	a_no_ie_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!s_q.ie
		|-> !ev[SMR_EV_CHANGE])
		else $error("change event while disabled");

	a_on_ie_event: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		s_q.ie
		|-> !ev[SMR_EV_ENABLE])
		else $error("enable event repeated");

	a_pend_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s_q.pend && !irq_ack_i)
		|=> s_q.pend)
		else $error("pending lost without acknowledge");

	a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		|(s_d.irq_st & s_d.irq_en)
		|=> irq_o)
		else $error("interrupt output missing");

	a_irq_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!(|(s_d.irq_st & s_d.irq_en))
		|=> !irq_o)
		else $error("interrupt output without cause");

	a_cpu_irq_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(s_d.pend && s_d.ie && !cpu_mask_i)
		|=> cpu_irq_o)
		else $error("cpu request missing");

	a_cpu_irq_ie: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		!s_d.ie
		|=> !cpu_irq_o)
		else $error("cpu request while disabled");

	a_halt_no_wake: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		halt_i
		|=> !wake_o)
		else $error("wake raised in halt");

	a_wake_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!halt_i && s_d.pend && s_d.ie)
		|=> wake_o)
		else $error("wake missing in wait");

endmodule : smr_top
`default_nettype wire

// File: verification/smr_env_model.sv
`default_nettype none
module smr_env_model
#(
	parameter logic [7:0] RISE_LVL = 8'h80,
	parameter logic [7:0] FALL_LVL = 8'h70
)(
	input  wire logic       clk_i,
	input  wire logic [7:0] vdd_i,
	input  wire logic [7:0] vsense_i,
	input  wire logic       irq_i,
	input  wire logic       mask_i,
	input  wire logic       ack_en_i,
	output logic            cmp_supply_o,
	output logic            cmp_sense_o,
	output logic            ack_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// comparators with hysteresis; between the two levels the old state holds
	always_ff @(posedge clk_i)
	begin
		cmp_supply_o <= (vdd_i < FALL_LVL) | (cmp_supply_o & (vdd_i <= RISE_LVL));
		cmp_sense_o  <= (vsense_i < FALL_LVL) | (cmp_sense_o & (vsense_i <= RISE_LVL));
		// cpu takes the vector only with its global mask cleared
		ack_o        <= irq_i & ~mask_i & ack_en_i & ~ack_o;
	end
endmodule // smr_env_model
`default_nettype wire

// File: verification/supply_monitor_reset_flags_tb_top.sv
`default_nettype none
module supply_monitor_reset_flags_tb_top
	import smr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i = 1'b0, sys_rst_i = 1'b1, lowvolt_det_en_i = 1'b1, long_delay_i = 1'b1;
	logic       halt_i = 1'b0, cpu_mask_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ack_en = 1'b0;
	logic [1:0] rst_src_i = 2'h0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00, vdd = 8'hff, vsense = 8'hff, rdata_o, v;
	logic       cmp_supply_i, cmp_sense_i, irq_ack_i, cpu_irq_o, wake_o, irq_o;
	int         bad_count = 0, checks = 0;
	always #4 clk_i = ~clk_i;
	// short reset delay keeps the run brief
	smr_top #(.RESET_DELAY_LONG(13'h0010), .RESET_DELAY_SHORT(13'h0008)) dut_u (.clk_i,
		.sys_rst_i, .rst_src_i, .lowvolt_det_en_i, .long_delay_i, .cmp_supply_i, .cmp_sense_i,
		.halt_i, .cpu_mask_i, .irq_ack_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.cpu_irq_o, .wake_o, .irq_o);
	smr_env_model env_u (.clk_i, .vdd_i(vdd), .vsense_i(vsense), .irq_i(cpu_irq_o),
		.mask_i(cpu_mask_i), .ack_en_i(ack_en), .cmp_supply_o(cmp_supply_i),
		.cmp_sense_o(cmp_sense_i), .ack_o(irq_ack_i));
	// ==========================================================
	// bus and check tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
		chk(v, exp);
	endtask
	task automatic rst(input logic [1:0] s, input int n);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		rst_src_i <= s;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (n) @(posedge clk_i);
	endtask
	task automatic report_and_stop;
		$display("counts: checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial
	begin
		rst(2'h2, 24);
		rc(SMR_ADDR_CSR, 8'h10);
		rst(2'h1, 24);
		rc(SMR_ADDR_CSR, 8'h11);
		wr(SMR_ADDR_CSR, 8'h00);
		rc(SMR_ADDR_CSR, 8'h00);
		rc(4'hf, 8'h00);
		$display("test reset flags done");
		wr(SMR_ADDR_IRQ_EN, 8'h03);
		wr(SMR_ADDR_CSR, 8'h40);
		vdd <= 8'h60;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_CSR, 8'h60);
		rc(SMR_ADDR_IRQ_ST, 8'h01);
		chk({7'h00, irq_o}, 8'h01);
		ack_en <= 1'b1;
		cpu_mask_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1;
		chk({7'h00, cpu_irq_o}, 8'h00);
		chk({7'h00, wake_o}, 8'h01);
		cpu_mask_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk({7'h00, cpu_irq_o}, 8'h01);
		repeat (3) @(posedge clk_i);
		#1;
		chk({7'h00, cpu_irq_o}, 8'h00);
		chk({7'h00, wake_o}, 8'h00);
		wr(SMR_ADDR_IRQ_CLR, 8'h03);
		vdd <= 8'hff;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_IRQ_ST, 8'h01);
		$display("test flag interrupt done");
		ack_en <= 1'b0;
		wr(SMR_ADDR_CSR, 8'hc0);
		vdd <= 8'h60;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_CSR, 8'hc0);
		vsense <= 8'h60;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_CSR, 8'he0);
		chk({7'h00, wake_o}, 8'h01);
		halt_i <= 1'b1;
		wr(SMR_ADDR_CSR, 8'h00);
		rc(SMR_ADDR_CSR, 8'he0);
		chk({7'h00, wake_o}, 8'h00);
		halt_i <= 1'b0;
		wr(SMR_ADDR_CSR, 8'h80);
		wr(SMR_ADDR_IRQ_CLR, 8'h03);
		wr(SMR_ADDR_CSR, 8'hc0);
		rc(SMR_ADDR_IRQ_ST, 8'h02);
		vsense <= 8'hff;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_IRQ_ST, 8'h03);
		$display("test select and halt done");
		wr(SMR_ADDR_IRQ_CLR, 8'h03);
		lowvolt_det_en_i <= 1'b0;
		vsense <= 8'h60;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_IRQ_ST, 8'h00);
		rc(SMR_ADDR_CSR, 8'hc0);
		lowvolt_det_en_i <= 1'b1;
		vdd <= 8'h60;
		rst(2'h0, 0);
		// enable during the delay so that the silent crossings are really tested
		wr(SMR_ADDR_CSR, 8'h40);
		vdd <= 8'hff;
		repeat (24) @(posedge clk_i);
		rc(SMR_ADDR_IRQ_ST, 8'h00);
		rc(SMR_ADDR_CSR, 8'h40);
		vdd <= 8'h60;
		repeat (4) @(posedge clk_i);
		rc(SMR_ADDR_IRQ_ST, 8'h01);
		$display("test option and delay done");
		report_and_stop();
	end
	initial
	begin
		#100000;
		bad_count++;
		report_and_stop();
	end
endmodule // supply_monitor_reset_flags_tb_top
`default_nettype wire
